// ==== core/boot_consts.svh ====
`ifndef BOOT_CONSTS_SVH
`define BOOT_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// Register map and control field positions.
`define CTRL_OFS    16'h2400
`define CTRL_RST    8'h02
`define F_DUAL      0
`define F_SPEED     1
`define F_MODE3     2
`define F_EXT       3
`define F_BUSY      4
`define F_PROBED    5

////////////////////////////////////////////////////////////////////////
// Flash layout, signature and read commands.
`define SIG_ADDR    24'h00_FFFA
`define SIG_WORD    32'h3244_4655
`define SIG_LEN     3'h4
`define FETCH_LEN   3'h1
`define BOOT_ADDR   24'h00_0000
`define CMD_READ1   8'h03
`define CMD_READ2   8'h3B
`define HDR_LAST    5'h1F
`define DUMMY_LAST  5'h07
`define BYTE_LAST1  5'h07
`define BYTE_LAST2  5'h03

////////////////////////////////////////////////////////////////////////
// Clock rates in MHz; the slow rate divides the link ticks.
`define RATE_FAST_MHZ 60
`define RATE_SLOW_MHZ 30
`define RATE_RATIO    (`RATE_FAST_MHZ / `RATE_SLOW_MHZ)

`endif

// ==== core/boot_pkg.sv ====
package boot_pkg;

    // Boot selection sequence in the system domain.
    typedef enum logic [2:0] {ST_START, ST_PROBE, ST_CHECK, ST_EXT, ST_FETCH, ST_INT} boot_st_t;

    // Serial transfer phases in the link domain.
    typedef enum logic [2:0] {L_IDLE, L_SEND, L_DUMMY, L_DATA, L_END} link_st_t;

endpackage : boot_pkg

// ==== core/bit_sync.sv ====
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Two flops per bit; the first one is read only by the second.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
        end
    end

endmodule : bit_sync

// ==== core/spi_read_engine.sv ====
`include "boot_consts.svh"

module spi_read_engine
    import boot_pkg::*;
(
    input  wire logic        link_clk,
    input  wire logic        rst_b,
    input  wire logic        req_tgl,
    input  wire logic [23:0] req_addr,
    input  wire logic [2:0]  req_len,
    input  wire logic        req_dual,
    input  wire logic        req_cpol,
    input  wire logic        req_fast,
    input  wire logic        spi_di,
    input  wire logic        pin_di,
    output logic             byte_tgl,
    output logic      [7:0]  byte_data,
    output logic             done_tgl,
    output logic             spi_cs_n,
    output logic             spi_sck,
    output logic             mosi,
    output logic             mosi_oe_n
);

    link_st_t    st_q;
    logic [1:0]  sync_s;
    logic        seen_q, dual_q, cpol_q, fast_q, ph_q, div_q;
    logic [31:0] sh_q;
    logic [4:0]  cnt_q;
    logic [2:0]  len_q;
    logic [7:0]  rx_q;

    // Reset and request toggle enter this domain through two flops.
    bit_sync #(.W(2)) u_sync (
        .clk (link_clk),
        .d   ({rst_b, req_tgl}),
        .q   (sync_s)
    );

    wire       lrst_b  = sync_s[1];
    wire       req_ev  = (st_q == L_IDLE) && (sync_s[0] != seen_q);
    wire       running = (st_q != L_IDLE) && (st_q != L_END);
    wire       tick    = running && (fast_q || div_q);
    wire       rise    = tick && !ph_q;
    wire       fall    = tick && ph_q;
    wire [4:0] dlast   = dual_q ? `BYTE_LAST2 : `BYTE_LAST1;
    wire [7:0] rx_d    = dual_q ? {rx_q[5:0], spi_di, pin_di} : {rx_q[6:0], spi_di};
    wire       emit    = rise && (st_q == L_DATA) && (cnt_q == 5'h00);

    ////////////////////////////////////////////////////////////////////
    // Transfer sequencer: header, optional dummy clocks, data bytes.
    always_ff @(posedge link_clk) begin
        if (!lrst_b) begin
            st_q <= L_IDLE;
        end else begin
            case (st_q)
                L_IDLE:  if (req_ev) st_q <= L_SEND;
                L_SEND:  if (fall && cnt_q == 5'h00) st_q <= dual_q ? L_DUMMY : L_DATA;
                L_DUMMY: if (fall && cnt_q == 5'h00) st_q <= L_DATA;
                L_DATA:  if (fall && cnt_q == 5'h00 && len_q == 3'h0) st_q <= L_END;
                L_END:   st_q <= L_IDLE;
                default: st_q <= L_IDLE;
            endcase
        end
    end

    // Request capture; the requester holds the fields stable meanwhile.
    always_ff @(posedge link_clk) begin
        if (!lrst_b) begin
            seen_q <= 1'b0;
            dual_q <= 1'b0;
            cpol_q <= 1'b0;
            fast_q <= 1'b0;
        end else if (req_ev) begin
            seen_q <= sync_s[0];
            dual_q <= req_dual;
            cpol_q <= req_cpol;
            fast_q <= req_fast;
        end
    end

    // Clock phase and slow-rate divider; slow ticks every other cycle.
    always_ff @(posedge link_clk) begin
        if (!lrst_b || !running) begin
            ph_q  <= 1'b0;
            div_q <= 1'b0;
        end else begin
            div_q <= !div_q;
            ph_q  <= ph_q ^ tick;
        end
    end

    // Header shifter and bit counter, advanced on falling clock edges.
    always_ff @(posedge link_clk) begin
        if (!lrst_b) begin
            sh_q  <= 32'h0000_0000;
            cnt_q <= 5'h00;
            len_q <= 3'h0;
        end else if (req_ev) begin
            sh_q  <= {req_dual ? `CMD_READ2 : `CMD_READ1, req_addr};
            cnt_q <= `HDR_LAST;
            len_q <= req_len;
        end else begin
            if (emit) len_q <= len_q - 3'h1;
            if (fall) begin
                sh_q  <= {sh_q[30:0], 1'b0};
                if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
                else if (st_q == L_SEND) cnt_q <= dual_q ? `DUMMY_LAST : `BYTE_LAST1;
                else cnt_q <= dlast;
            end
        end
    end

    // Receive one or two bits on each rising edge and hand bytes over.
    always_ff @(posedge link_clk) begin
        if (!lrst_b) begin
            rx_q      <= 8'h00;
            byte_data <= 8'h00;
            byte_tgl  <= 1'b0;
            done_tgl  <= 1'b0;
        end else begin
            if (rise && st_q == L_DATA) rx_q <= rx_d;
            if (emit) byte_data <= rx_d;
            if (emit) byte_tgl <= !byte_tgl;
            if (st_q == L_END) done_tgl <= !done_tgl;
        end
    end

    // Pin drivers: select while busy, data line let go for dual input.
    always_ff @(posedge link_clk) begin
        if (!lrst_b) begin
            spi_cs_n  <= 1'b1;
            mosi_oe_n <= 1'b0;
        end else begin
            spi_cs_n  <= !(req_ev || running);
            mosi_oe_n <= running && dual_q && (st_q != L_SEND || (fall && cnt_q == 5'h00));
        end
    end

    // Idle level follows the chosen mode; active level is the phase.
    assign spi_sck = spi_cs_n ? cpol_q : ph_q;
    assign mosi    = sh_q[31];

    dual_release_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        (st_q == L_DATA && dual_q) |-> mosi_oe_n)
        else $error("data line driven during dual input");
    idle_level_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        (st_q == L_END) |-> (!ph_q && !spi_cs_n))
        else $error("frame ended off the clock idle phase");
    slow_rate_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        (tick && !fast_q && st_q != L_END) |=> !tick)
        else $error("slow rate ticked twice in a row");
    fast_rate_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        (running && fast_q) |=> $changed(spi_sck))
        else $error("fast rate missed a tick");

endmodule : spi_read_engine

// ==== core/spi_rom_boot_select.sv ====
// Overview of operation
// - After reset, read the flash signature starting at the fixed high address first.
// - Valid signature selects external boot and fetching from flash address zero.
// - Without a valid signature, stay on internal code and never switch.
// - During reset the strap pin floats with its weak pull-down on.
// - At reset release, latch the strap, drop the pull-down, drive data out.
// - The latched rate reads back in the control register, reset value given.
// - Transfers use either one or two data lines per clock.
// - The serial port works in clock mode 0 or mode 3.
// - Clock the port at the slow rate for strap zero, fast for one.
// - In suspend, float the data pin for strap one, drive low for zero.
`include "boot_consts.svh"

module spi_rom_boot_select
    import boot_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        link_clk,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        suspend,
    input  wire logic        fetch_req,
    input  wire logic [23:0] fetch_addr,
    output logic             fetch_ready,
    output logic      [7:0]  fetch_data,
    output logic             fetch_valid,
    output logic             ext_boot,
    output logic             boot_done,
    output logic      [23:0] boot_addr,
    output logic             spi_cs_n,
    output logic             spi_sck,
    input  wire logic        spi_di,
    input  wire logic        rate_strap_pin_i,
    output logic             rate_strap_pin_o,
    output logic             rate_strap_pin_oe_n,
    output logic             rate_strap_pd_en
);

    ////////////////////////////////////////////////////////////////////
    // Declarations.
    boot_st_t    st_q, st_d;
    logic [2:0]  sync_s;
    logic        strap_done_q, rate_fast_q;
    logic        dual_q, mode3_q, ext_q;
    logic        byte_seen_q, done_seen_q;
    logic [31:0] sig_q;
    logic        req_tgl_q, req_dual_q, req_cpol_q, req_fast_q;
    logic [23:0] req_addr_q;
    logic [2:0]  req_len_q;
    logic        link_byte_tgl, link_done_tgl, link_mosi, link_oe_n;
    logic [7:0]  link_byte;

    ////////////////////////////////////////////////////////////////////
    // Crossings into the system domain: strap pin and two event toggles.
    bit_sync #(.W(3)) u_sync (
        .clk (sys_clk),
        .d   ({rate_strap_pin_i, link_byte_tgl, link_done_tgl}),
        .q   (sync_s)
    );

    wire strap_s = sync_s[2];
    wire byte_ev = sync_s[1] != byte_seen_q;
    wire done_ev = sync_s[0] != done_seen_q;

    // Remember the last toggle level seen on each event line.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            byte_seen_q <= 1'b0;
            done_seen_q <= 1'b0;
        end else begin
            byte_seen_q <= sync_s[1];
            done_seen_q <= sync_s[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Rate strap: held floating in reset, caught on the first edge after.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            strap_done_q <= 1'b0;
            rate_fast_q  <= 1'(`CTRL_RST >> `F_SPEED);
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            rate_fast_q  <= strap_s;
        end
    end

    // Pull-down stays on only until the strap is captured.
    assign rate_strap_pd_en = !strap_done_q;

    // Shared pin: floats before capture, suspend level by strap, else data.
    wire susp_float = suspend && rate_fast_q;
    wire link_float = !suspend && link_oe_n;
    assign rate_strap_pin_oe_n = !strap_done_q || susp_float || link_float;
    assign rate_strap_pin_o    = suspend ? 1'b0 : link_mosi;

    ////////////////////////////////////////////////////////////////////
    // Register port: one control register, everything else reads zero.
    wire ctrl_hit = reg_addr == `CTRL_OFS;
    wire ctrl_wr  = reg_wr && ctrl_hit;
    wire ctrl_rd  = reg_rd && ctrl_hit;
    wire busy     = (st_q == ST_PROBE) || (st_q == ST_FETCH);
    wire probed   = (st_q == ST_EXT) || (st_q == ST_FETCH) || (st_q == ST_INT);

    wire [7:0] ctrl_val = 8'h00
        | (8'(dual_q)      << `F_DUAL)
        | (8'(rate_fast_q) << `F_SPEED)
        | (8'(mode3_q)     << `F_MODE3)
        | (8'(ext_q)       << `F_EXT)
        | (8'(busy)        << `F_BUSY)
        | (8'(probed)      << `F_PROBED);

    // Writable fields choose line count and clock mode for later reads.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dual_q  <= 1'(`CTRL_RST >> `F_DUAL);
            mode3_q <= 1'(`CTRL_RST >> `F_MODE3);
        end else if (ctrl_wr) begin
            dual_q  <= reg_wdata[`F_DUAL];
            mode3_q <= reg_wdata[`F_MODE3];
        end
    end

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) reg_rdata <= 8'h00;
        else reg_rdata <= ctrl_rd ? ctrl_val : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // Boot sequence: probe, compare, then serve fetches or stay inside.
    wire sig_match = sig_q == `SIG_WORD;
    wire fetch_go  = (st_q == ST_EXT) && fetch_req && !suspend;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_START: if (strap_done_q) st_d = ST_PROBE;
            ST_PROBE: if (done_ev) st_d = ST_CHECK;
            ST_CHECK: st_d = sig_match ? ST_EXT : ST_INT;
            ST_EXT:   if (fetch_go) st_d = ST_FETCH;
            ST_FETCH: if (done_ev) st_d = ST_EXT;
            ST_INT:   st_d = ST_INT;
            default:  st_d = ST_START;
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) st_q <= ST_START;
        else st_q <= st_d;
    end

    // Signature bytes shift in most significant first.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) sig_q <= 32'h0000_0000;
        else if (st_q == ST_PROBE && byte_ev) sig_q <= {sig_q[23:0], link_byte};
    end

    // External boot is taken once, only on an exact match.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) ext_q <= 1'b0;
        else if (st_q == ST_CHECK && sig_match) ext_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // Read requests toward the link domain, fields stable until done.
    wire probe_go = (st_q == ST_START) && strap_done_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_tgl_q  <= 1'b0;
            req_addr_q <= `BOOT_ADDR;
            req_len_q  <= 3'h0;
        end else if (probe_go) begin
            req_tgl_q  <= !req_tgl_q;
            req_addr_q <= `SIG_ADDR;
            req_len_q  <= `SIG_LEN;
        end else if (fetch_go) begin
            req_tgl_q  <= !req_tgl_q;
            req_addr_q <= fetch_addr;
            req_len_q  <= `FETCH_LEN;
        end
    end

    // Transfer options follow the control register; the rate is the synchronized strap for the probe, the latched strap for fetches.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_dual_q <= 1'b0;
            req_cpol_q <= 1'b0;
            req_fast_q <= 1'b0;
        end else if (probe_go || fetch_go) begin
            req_dual_q <= dual_q;
            req_cpol_q <= mode3_q;
            req_fast_q <= probe_go ? strap_s : rate_fast_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fetch answer: byte captured on arrival, valid pulses at the end.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            fetch_data  <= 8'h00;
            fetch_valid <= 1'b0;
        end else begin
            if (st_q == ST_FETCH && byte_ev) fetch_data <= link_byte;
            fetch_valid <= (st_q == ST_FETCH) && done_ev;
        end
    end

    // Boot status outputs.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            boot_done <= 1'b0;
            boot_addr <= `BOOT_ADDR;
        end else begin
            boot_done <= probed;
            boot_addr <= `BOOT_ADDR;
        end
    end

    assign ext_boot    = ext_q;
    assign fetch_ready = (st_q == ST_EXT) && !suspend;

    ////////////////////////////////////////////////////////////////////
    // Link-side serial engine on its own clock.
    spi_read_engine u_engine (
        .link_clk  (link_clk),
        .rst_b     (rst_b),
        .req_tgl   (req_tgl_q),
        .req_addr  (req_addr_q),
        .req_len   (req_len_q),
        .req_dual  (req_dual_q),
        .req_cpol  (req_cpol_q),
        .req_fast  (req_fast_q),
        .spi_di    (spi_di),
        .pin_di    (rate_strap_pin_i),
        .byte_tgl  (link_byte_tgl),
        .byte_data (link_byte),
        .done_tgl  (link_done_tgl),
        .spi_cs_n  (spi_cs_n),
        .spi_sck   (spi_sck),
        .mosi      (link_mosi),
        .mosi_oe_n (link_oe_n)
    );

    ////////////////////////////////////////////////////////////////////
    // Checks on the system-domain behaviour.
    probe_first_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_q == ST_START && strap_done_q) |=> (st_q == ST_PROBE && req_addr_q == `SIG_ADDR
            && req_len_q == `SIG_LEN))
        else $error("probe did not start at signature address");

    ext_select_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_q == ST_CHECK && sig_match) |=> (ext_boot && st_q == ST_EXT) ##1 (boot_addr == `BOOT_ADDR))
        else $error("valid signature did not select external boot");

    int_stays_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_q == ST_INT) |=> (st_q == ST_INT && !ext_boot && !fetch_ready && $stable(req_tgl_q)))
        else $error("internal boot left or requested flash");

    strap_float_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!strap_done_q) |-> (rate_strap_pin_oe_n && rate_strap_pd_en))
        else $error("strap pin driven or pull-down off before capture");

    strap_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(strap_done_q) |-> (rate_fast_q == $past(strap_s) && !rate_strap_pd_en))
        else $error("strap level not latched at release");

    rate_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl_rd |=> (reg_rdata[`F_SPEED] == rate_fast_q && reg_rdata[7:6] == 2'b00))
        else $error("control read does not show latched rate");

    susp_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (suspend && strap_done_q) |-> (rate_fast_q ? rate_strap_pin_oe_n
            : (!rate_strap_pin_oe_n && !rate_strap_pin_o)))
        else $error("suspend level on strap pin wrong");

    mismatch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_q == ST_CHECK && !sig_match) |=> (st_q == ST_INT) [*2])
        else $error("bad signature did not fall back");

    rate_req_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fetch_go |=> (req_fast_q == rate_fast_q))
        else $error("fetch rate differs from latched strap");

endmodule : spi_rom_boot_select

// ==== test/flash_model.sv ====
// Serial flash that answers read commands in single or dual line form.
module flash_model (
    input  wire logic sig_ok,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic io0_in,
    output logic      io1_out,
    output logic      io0_out,
    output logic      io0_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] hdr = 32'h0000_0000;
    logic [7:0]  sh  = 8'h00;
    logic [23:0] a   = 24'h00_0000;
    int          cnt = 0;
    int          nb  = 0;
    wire logic   dual = (hdr[31:24] === 8'h3B);

    initial begin
        io1_out = 1'b0;
        io0_out = 1'b0;
        io0_oe  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Content: the upgrade mark near the top of the first 64 KB, a
    // pattern elsewhere. A cleared sig_ok spoils only the last mark byte.
    function automatic logic [7:0] byte_at(input logic [23:0] ad, input logic ok);
        logic [31:0] sig;
        logic [23:0] off;
        sig = 32'h3244_4655 ^ {31'h0000_0000, !ok};
        off = ad - 24'h00_FFFA;
        if (off < 24'h00_0004) return sig[31 - 8 * off[1:0] -: 8];
        return ad[7:0] ^ ad[15:8] ^ ad[23:16] ^ 8'hA5;
    endfunction : byte_at

    ////////////////////////////////////////////////////////////////////////
    // A frame starts on select; on deselect both data lines are let go.
    always @(negedge cs_n) begin
        cnt = 0;
        nb  = 0;
    end
    always @(posedge cs_n) begin
        io0_oe  = 1'b0;
        io1_out = 1'b0; // The pull-down of the data-in pad takes over.
    end

    // Command and 24-bit address come in MSB first on rising clock edges.
    always @(posedge sck) begin
        if (!cs_n) begin
            if (cnt < 32) hdr = {hdr[30:0], io0_in};
            cnt++;
            if (cnt == 32) a = hdr[23:0]; // Full 24-bit space, well above one megabit
        end
    end

    // Data leave on falling edges, after eight dummy clocks in dual form.
    always @(negedge sck) begin
        if (!cs_n && cnt >= (dual ? 40 : 32)) begin
            if (nb == 0) begin
                sh = byte_at(a, sig_ok);
                a++;
            end
            io1_out = sh[7];
            if (dual) begin // Dual output read is offered
                io0_out = sh[6];
                io0_oe  = 1'b1;
                sh      = {sh[5:0], 2'b00};
                nb      = (nb + 1) % 4;
            end else begin
                sh = {sh[6:0], 1'b0};
                nb = (nb + 1) % 8;
            end
        end
    end
endmodule : flash_model

// ==== test/spi_rom_boot_select_bench.sv ====
`include "boot_consts.svh"

// Drives the boot selector against the flash model and checks its results.
module spi_rom_boot_select_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic suspend = 1'b0, fetch_req = 1'b0, strap_v = 1'b0, sig_ok = 1'b0, rd_d = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic [23:0] fetch_addr = 24'h00_0000;
    logic [31:0] seed = 32'h0001_6DA3;
    logic [7:0]  reg_rdata, fetch_data;
    logic [23:0] boot_addr;
    logic        fetch_ready, fetch_valid, ext_boot, boot_done, spi_cs_n, spi_sck, spi_di;
    logic        pin_o, pin_oe_n, pd_en, fl_io0, fl_oe;
    logic [7:0]  exp_q[$];
    int          err_count = 0;
    int          cmp_count = 0;
    // The shared pin: device, then flash, else the strap resistor.
    wire logic   pin = !pin_oe_n ? pin_o : (fl_oe ? fl_io0 : strap_v);

    ////////////////////////////////////////////////////////////////////////
    // Clocks of unrelated phase.
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    spi_rom_boot_select dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .suspend(suspend), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .fetch_ready(fetch_ready), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
        .ext_boot(ext_boot), .boot_done(boot_done), .boot_addr(boot_addr),
        .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_di(spi_di), .rate_strap_pin_i(pin),
        .rate_strap_pin_o(pin_o), .rate_strap_pin_oe_n(pin_oe_n), .rate_strap_pd_en(pd_en));

    flash_model flash (.sig_ok(sig_ok), .cs_n(spi_cs_n), .sck(spi_sck), .io0_in(pin),
        .io1_out(spi_di), .io0_out(fl_io0), .io0_oe(fl_oe));

    ////////////////////////////////////////////////////////////////////////
    // Helpers: random source, comparison, verdict.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic results();
        check("pending", 32'h0000_0000, exp_q.size());
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Pairs each read or fetch result with the oldest noted expectation.
    always @(posedge sys_clk) begin
        if (rd_d) begin
            if (exp_q.size() == 0) check("reg_rdata", 32'h0000_0100, reg_rdata);
            else check("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
        if (fetch_valid === 1'b1) begin
            if (exp_q.size() == 0) check("fetch_data", 32'h0000_0100, fetch_data);
            else check("fetch_data", exp_q.pop_front(), fetch_data);
        end
        rd_d <= reg_rd;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access: a write, or a read whose expected value is noted.
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        if (!w) exp_q.push_back(d);
        reg_addr  <= a;
        reg_wdata <= w ? d : 8'h00;
        reg_wr    <= w;
        reg_rd    <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    // One fetch, expected byte worked out from the flash content.
    task automatic fetch(input logic [23:0] a);
        int i;
        for (i = 0; i < 9000 && fetch_ready !== 1'b1; i++) @(posedge sys_clk);
        check("fetch_ready", 32'h0000_0001, fetch_ready);
        exp_q.push_back(flash.byte_at(a, 1'b1));
        fetch_addr <= a;
        fetch_req  <= 1'b1;
        @(posedge sys_clk);
        fetch_req <= 1'b0;
        for (i = 0; i < 9000 && fetch_valid !== 1'b1; i++) @(posedge sys_clk);
        check("fetch_valid", 32'h0000_0001, fetch_valid);
        @(posedge sys_clk);
    endtask : fetch

    // One boot with a given strap and mark; reset is long enough for the link side.
    task automatic run(input logic s, input logic ok);
        int i;
        time t0;
        logic [31:0] r;
        rst_b   <= 1'b0;
        strap_v <= s;
        sig_ok  <= ok;
        repeat (64) @(posedge sys_clk);
        check("strap_oe_n", 32'h0000_0001, pin_oe_n);
        check("strap_pd", 32'h0000_0001, pd_en);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("pd_off", 32'h0000_0000, pd_en);
        check("do_drive", 32'h0000_0000, pin_oe_n);
        @(posedge spi_sck);
        t0 = $time;
        @(posedge spi_sck);
        check("sck_period", s ? 32'h0000_0140 : 32'h0000_0280, 32'($time - t0));
        @(posedge sys_clk);
        for (i = 0; i < 20000 && boot_done !== 1'b1; i++) @(posedge sys_clk);
        check("boot_done", 32'h0000_0001, boot_done);
        check("ext_boot", {31'h0000_0000, ok}, ext_boot);
        check("boot_addr", 32'h0000_0000, boot_addr);
        bus(1'b0, `CTRL_OFS, {2'b00, 1'b1, 1'b0, ok, 1'b0, s, 1'b0});
        r = rnd();
        bus(1'b1, `CTRL_OFS, r[7:0]);
        bus(1'b0, `CTRL_OFS, {2'b00, 1'b1, 1'b0, ok, r[2], s, r[0]});
        bus(1'b1, 16'h2404, r[15:8]);
        bus(1'b0, 16'h2404, 8'h00);
        if (ok) begin
            for (i = 0; i < 4; i++) begin
                bus(1'b1, `CTRL_OFS, {5'h00, i[1], 1'b0, i[0]});
                r = rnd();
                fetch(r[23:0]);
                check("cs_idle", 32'h0000_0001, spi_cs_n);
                check("sck_idle", {31'h0000_0000, i[1]}, spi_sck);
            end
        end else begin
            check("fetch_ready", 32'h0000_0000, fetch_ready);
        end
        suspend <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("susp_oe_n", {31'h0000_0000, s}, pin_oe_n);
        if (!s) check("susp_level", 32'h0000_0000, pin_o);
        check("susp_ready", 32'h0000_0000, fetch_ready);
        suspend <= 1'b0;
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    // Main sequence over every strap and mark combination, plus a watchdog.
    initial begin
        for (int k = 0; k < 4; k++) run(k[0], k[1]);
        results();
    end
    initial begin
        #800000;
        err_count++;
        results();
    end
endmodule : spi_rom_boot_select_bench
